// ### rtl/inc_unit.sv
`timescale 1ns/1ps

module inc_unit
    import jump_inc_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH
)
(
    input  wire logic             clock_in,        // core clock
    input  wire logic             reset_in,        // sync reset, high
    input  wire logic             load_in,         // compute strobe
    input  wire logic [WIDTH-1:0] operand_in,      // byte to increment
    output logic      [WIDTH-1:0] result_out,      // operand plus one
    output logic                  carry_out,       // carry from msb
    output logic                  half_carry_out,  // carry from bit 3
    output logic                  negative_out,    // msb of result
    output logic                  overflow_out,    // signed overflow
    output logic                  zero_out         // result is zero
);

    if (WIDTH < 5)
    begin : g_width_check
        $error("inc_unit needs at least 5 bits");
    end

    // =====================================================================
    // adder
    // =====================================================================
    wire logic [WIDTH:0] sum      = {1'b0, operand_in} + {{WIDTH{1'b0}}, 1'b1};
    wire logic [4:0]     low_sum  = {1'b0, operand_in[3:0]} + 5'h01;
    wire logic           next_ovf = ~operand_in[WIDTH-1] & sum[WIDTH-1];

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            result_out     <= '0;
            carry_out      <= 1'b0;
            half_carry_out <= 1'b0;
            negative_out   <= 1'b0;
            overflow_out   <= 1'b0;
            zero_out       <= 1'b0;
        end
        else if (load_in)
        begin
            result_out     <= sum[WIDTH-1:0];
            carry_out      <= sum[WIDTH];
            half_carry_out <= low_sum[4];
            negative_out   <= sum[WIDTH-1];
            overflow_out   <= next_ovf;
            zero_out       <= (sum[WIDTH-1:0] == '0);
        end
    end

endmodule // inc_unit

// ### rtl/jump_and_increment_exec.sv
`timescale 1ns/1ps

module jump_and_increment_exec
    import jump_inc_pkg::*;
(
    input  wire logic                       clock_in,         // core clock, 125 MHz
    input  wire logic                       reset_in,         // sync reset, high
    input  wire logic                       instr_valid_in,   // fetched word present
    input  wire logic [WORD_WIDTH-1:0]      instr_word_in,    // word at Q1
    input  wire logic [WORD_WIDTH-1:0]      next_word_in,     // following word, by Q4
    input  wire logic                       extended_en_in,   // extended set on
    input  wire logic [BANK_WIDTH-1:0]      bank_pointer_in,  // bank pointer
    input  wire logic [DATA_ADDR_WIDTH-1:0] index_base_in,    // index base register
    input  wire logic [DATA_WIDTH-1:0]      mem_rdata_in,     // data byte, in Q3
    output quarter_e                        quarter_out,      // current quarter
    output logic [DATA_ADDR_WIDTH-1:0]      mem_addr_out,     // data address
    output logic                            mem_read_out,     // read strobe, Q2
    output logic                            mem_write_out,    // write strobe, Q4
    output logic [DATA_WIDTH-1:0]           mem_wdata_out,    // write data
    output logic [DATA_WIDTH-1:0]           wreg_out,         // working accumulator
    output logic [FLAG_COUNT-1:0]           flags_out,        // sign ovf zero half carry
    output logic [PC_WIDTH-1:0]             pc_out,           // program counter
    output logic                            pc_write_out,     // counter load, Q4
    output logic                            flush_out         // jump second cycle
);

    // =====================================================================
    // quarter sequencer
    // =====================================================================
    quarter_e quarter;
    quarter_e next_quarter;

    always_comb
    begin
        unique case (quarter)
            QUARTER_1: next_quarter = QUARTER_2;
            QUARTER_2: next_quarter = QUARTER_3;
            QUARTER_3: next_quarter = QUARTER_4;
            QUARTER_4: next_quarter = QUARTER_1;
            default:   next_quarter = QUARTER_1;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            quarter <= QUARTER_1;
        else
            quarter <= next_quarter;
    end

    assign quarter_out = quarter;

    wire logic in_q1 = (quarter == QUARTER_1);
    wire logic in_q2 = (quarter == QUARTER_2);
    wire logic in_q3 = (quarter == QUARTER_3);
    wire logic in_q4 = (quarter == QUARTER_4);

    // =====================================================================
    // decode
    // =====================================================================
    wire logic       take_word  = in_q1 & instr_valid_in & ~flush_out;
    wire logic       is_jump    = (instr_word_in[JUMP_FIRST_MSB:JUMP_FIRST_LSB]
                                   == JUMP_FIRST_PATTERN);
    wire logic       is_inc     = (instr_word_in[WORD_WIDTH-1:INC_PATTERN_LSB]
                                   == INC_PATTERN);
    wire logic [7:0] file_addr  = instr_word_in[7:0];
    wire logic       access_sel = instr_word_in[ACCESS_BIT];
    wire logic       literal_mode = ~access_sel & extended_en_in
                                    & (file_addr <= LITERAL_OFFSET_LIMIT);
    wire logic [BANK_WIDTH-1:0] access_bank = (file_addr < ACCESS_SPLIT)
                                              ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
    wire logic [DATA_ADDR_WIDTH-1:0] indexed_addr =
        DATA_ADDR_WIDTH'(index_base_in + {4'h0, file_addr});
    wire logic [DATA_ADDR_WIDTH-1:0] next_addr =
        literal_mode ? indexed_addr :
        access_sel   ? {bank_pointer_in, file_addr} :
                       {access_bank, file_addr};

    logic       op_jump;
    logic       op_inc;
    logic       dest_file;
    logic [7:0] target_low;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            op_jump      <= 1'b0;
            op_inc       <= 1'b0;
            dest_file    <= 1'b0;
            target_low   <= 8'h00;
            mem_addr_out <= '0;
        end
        else if (in_q1)
        begin
            op_jump      <= take_word & is_jump;
            op_inc       <= take_word & is_inc;
            dest_file    <= instr_word_in[DEST_BIT];
            target_low   <= instr_word_in[7:0];
            mem_addr_out <= next_addr;
        end
    end

    // =====================================================================
    // absolute jump
    // =====================================================================
    wire logic second_ok = (next_word_in[WORD_WIDTH-1:JUMP_SECOND_LSB]
                            == JUMP_SECOND_PATTERN);
    wire logic [TARGET_WIDTH-1:0] jump_target =
        {next_word_in[JUMP_SECOND_LSB-1:0], target_low};

    assign pc_write_out = op_jump & in_q4 & second_ok;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            pc_out    <= PC_RESET;
            flush_out <= 1'b0;
        end
        else if (in_q4)
        begin
            if (pc_write_out)
                pc_out <= {jump_target, 1'b0};
            flush_out <= pc_write_out;
        end
    end

    // =====================================================================
    // increment datapath
    // =====================================================================
    logic [DATA_WIDTH-1:0] alu_result;
    logic                  alu_c;
    logic                  alu_half;
    logic                  alu_n;
    logic                  alu_ovf;
    logic                  alu_z;

    inc_unit #(
        .WIDTH          (DATA_WIDTH)
    ) u_inc_unit (
        .clock_in       (clock_in),
        .reset_in       (reset_in),
        .load_in        (op_inc & in_q3),
        .operand_in     (mem_rdata_in),
        .result_out     (alu_result),
        .carry_out      (alu_c),
        .half_carry_out (alu_half),
        .negative_out   (alu_n),
        .overflow_out   (alu_ovf),
        .zero_out       (alu_z)
    );

    assign mem_read_out  = op_inc & in_q2;
    assign mem_write_out = op_inc & in_q4 & dest_file;
    assign mem_wdata_out = alu_result;

    wire logic [FLAG_COUNT-1:0] next_flags = {alu_n, alu_ovf, alu_z, alu_half, alu_c};

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            wreg_out  <= WREG_RESET;
            flags_out <= FLAGS_RESET;
        end
        else if (op_inc & in_q4)
        begin
            flags_out <= next_flags;
            if (!dest_file)
                wreg_out <= alu_result;
        end
    end

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    property p_jump_target;
        pc_write_out |=> pc_out == {$past(jump_target), 1'b0};
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

    property p_jump_decode;
        take_word && instr_word_in[15:8] == 8'hEF |=> op_jump && !op_inc;
    endproperty
    a_jump_decode: assert property (p_jump_decode) else $error("jump not decoded");

    property p_jump_two_cycles;
        pc_write_out |=> flush_out [*4] ##1 !flush_out;
    endproperty
    a_jump_two_cycles: assert property (p_jump_two_cycles)
        else $error("jump not two cycles");

    property p_jump_no_flags;
        op_jump |=> $stable(flags_out) && $stable(wreg_out);
    endproperty
    a_jump_no_flags: assert property (p_jump_no_flags)
        else $error("jump changed flags");

    property p_inc_value;
        mem_write_out |-> mem_wdata_out == 8'($past(mem_rdata_in) + 8'h01);
    endproperty
    a_inc_value: assert property (p_inc_value) else $error("increment wrong");

    property p_inc_zero_carry;
        op_inc && in_q4 |=> flags_out[FLAG_Z] == ($past(mem_rdata_in, 2) == 8'hFF)
                            && flags_out[FLAG_C] == flags_out[FLAG_Z];
    endproperty
    a_inc_zero_carry: assert property (p_inc_zero_carry)
        else $error("zero or carry wrong");

    property p_dest_wreg;
        op_inc && in_q4 && !dest_file |-> !mem_write_out ##1 wreg_out == $past(alu_result);
    endproperty
    a_dest_wreg: assert property (p_dest_wreg)
        else $error("result not in accumulator");

    property p_bank_select;
        take_word && is_inc && instr_word_in[8] |=> mem_addr_out[11:8] == $past(bank_pointer_in);
    endproperty
    a_bank_select: assert property (p_bank_select) else $error("bank pointer unused");

    property p_literal_offset;
        take_word && is_inc && !instr_word_in[8] && extended_en_in
            && instr_word_in[7:0] <= 8'h5F
        |=> mem_addr_out == 12'($past(index_base_in) + {4'h0, $past(instr_word_in[7:0])});
    endproperty
    a_literal_offset: assert property (p_literal_offset)
        else $error("indexed address wrong");

    property p_inc_quarters;
        take_word && is_inc
        |=> mem_read_out && !mem_write_out ##1 !mem_read_out ##1 in_q4 && !mem_read_out;
    endproperty
    a_inc_quarters: assert property (p_inc_quarters)
        else $error("quarter order wrong");

    c_jump:        cover property (pc_write_out);
    c_inc_to_wreg: cover property (op_inc && in_q4 && !dest_file);
    c_inc_wrap:    cover property (mem_write_out && mem_wdata_out == 8'h00);
    c_indexed:     cover property (take_word && is_inc && literal_mode);

endmodule // jump_and_increment_exec

// ### rtl/jump_inc_pkg.sv
package jump_inc_pkg;

    // =====================================================================
    // widths
    // =====================================================================
    localparam int DATA_WIDTH      = 8;
    localparam int WORD_WIDTH      = 16;
    localparam int PC_WIDTH        = 21;
    localparam int TARGET_WIDTH    = 20;
    localparam int DATA_ADDR_WIDTH = 12;
    localparam int BANK_WIDTH      = 4;
    localparam int FLAG_COUNT      = 5;

    // =====================================================================
    // opcode fields
    // =====================================================================
    localparam logic [7:0] JUMP_FIRST_PATTERN  = 8'hEF;
    localparam int         JUMP_FIRST_MSB      = 15;
    localparam int         JUMP_FIRST_LSB      = 8;
    localparam logic [3:0] JUMP_SECOND_PATTERN = 4'hF;
    localparam int         JUMP_SECOND_LSB     = 12;
    localparam logic [5:0] INC_PATTERN         = 6'h0A;
    localparam int         INC_PATTERN_LSB     = 10;
    localparam int         DEST_BIT            = 9;
    localparam int         ACCESS_BIT          = 8;

    // =====================================================================
    // data addressing
    // =====================================================================
    localparam logic [7:0] LITERAL_OFFSET_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT         = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK      = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK     = 4'hF;

    // =====================================================================
    // flag positions and reset values
    // =====================================================================
    localparam int FLAG_C  = 0;
    localparam int FLAG_HALF_CARRY = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OVERFLOW   = 3;
    localparam int FLAG_N  = 4;

    localparam logic [20:0] PC_RESET    = 21'h000000;
    localparam logic [7:0]  WREG_RESET  = 8'h00;
    localparam logic [4:0]  FLAGS_RESET = 5'h00;

    // =====================================================================
    // instruction cycle quarters (one clock each)
    // =====================================================================
    typedef enum logic [3:0] {
        QUARTER_1 = 4'b0001,
        QUARTER_2 = 4'b0010,
        QUARTER_3 = 4'b0100,
        QUARTER_4 = 4'b1000
    } quarter_e;

    localparam int JUMP_CYCLES = 2;

endpackage

// ### tb/jump_and_increment_exec_tb.sv
`timescale 1ns/1ps

`define CHECK(nm, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
        end \
    end

module jump_and_increment_exec_tb
    import jump_inc_pkg::*;
;
    // =====================================================================
    // signals
    // =====================================================================
    logic                       clock_in;
    logic                       reset_in;
    logic                       instr_valid_in;
    logic [WORD_WIDTH-1:0]      instr_word_in;
    logic [WORD_WIDTH-1:0]      next_word_in;
    logic                       extended_en_in;
    logic [BANK_WIDTH-1:0]      bank_pointer_in;
    logic [DATA_ADDR_WIDTH-1:0] index_base_in;
    logic [DATA_WIDTH-1:0]      mem_rdata_in;
    quarter_e                   quarter;
    logic [DATA_ADDR_WIDTH-1:0] mem_addr_out;
    logic                       mem_read_out;
    logic                       mem_write_out;
    logic [DATA_WIDTH-1:0]      mem_wdata_out;
    logic [DATA_WIDTH-1:0]      wreg_out;
    logic [FLAG_COUNT-1:0]      flags_out;
    logic [PC_WIDTH-1:0]        pc_out;
    logic                       pc_write_out;
    logic                       flush_out;
    logic [DATA_WIDTH-1:0]      exp_wreg;
    logic [FLAG_COUNT-1:0]      exp_flags;
    logic [PC_WIDTH-1:0]        exp_pc;
    int                         n_mismatch;
    int                         n_tests;

    jump_and_increment_exec dut (
        .clock_in        (clock_in),
        .reset_in        (reset_in),
        .instr_valid_in  (instr_valid_in),
        .instr_word_in   (instr_word_in),
        .next_word_in    (next_word_in),
        .extended_en_in  (extended_en_in),
        .bank_pointer_in (bank_pointer_in),
        .index_base_in   (index_base_in),
        .mem_rdata_in    (mem_rdata_in),
        .quarter_out     (quarter),
        .mem_addr_out    (mem_addr_out),
        .mem_read_out    (mem_read_out),
        .mem_write_out   (mem_write_out),
        .mem_wdata_out   (mem_wdata_out),
        .wreg_out        (wreg_out),
        .flags_out       (flags_out),
        .pc_out          (pc_out),
        .pc_write_out    (pc_write_out),
        .flush_out       (flush_out)
    );

    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    // =====================================================================
    // tasks
    // =====================================================================
    task automatic step();
        @(posedge clock_in);
        #1;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_reset();
        reset_in = 1'b1;
        repeat (10) step();
        reset_in  = 1'b0;
        exp_wreg  = WREG_RESET;
        exp_flags = FLAGS_RESET;
        exp_pc    = PC_RESET;
    endtask

    task automatic wait_q1();
        int k;
        k = 0;
        while (quarter !== QUARTER_1 && k < 8)
        begin
            step();
            k++;
        end
        if (quarter !== QUARTER_1)
        begin
            n_mismatch++;
            $display("MISMATCH quarter wait expected 1 seen %0h", quarter);
            wrap_up();
        end
    endtask

    task automatic inc(input logic [7:0] f, input logic d, input logic a, input logic ext,
                       input logic [3:0] bank, input logic [11:0] base,
                       input logic [7:0] rd, input logic [11:0] addr);
        logic [7:0] res;
        res = rd + 8'h01;
        wait_q1();
        instr_word_in   = {INC_PATTERN, d, a, f};
        instr_valid_in  = 1'b1;
        extended_en_in  = ext;
        bank_pointer_in = bank;
        index_base_in   = base;
        step();
        instr_valid_in = 1'b0;
        mem_rdata_in   = ~rd;
        `CHECK("quarter", QUARTER_2, quarter)
        `CHECK("read strobe", 1'b1, mem_read_out)
        `CHECK("data address", addr, mem_addr_out)
        step();
        mem_rdata_in = rd;
        `CHECK("read strobe end", 1'b0, mem_read_out)
        step();
        mem_rdata_in = ~rd;
        `CHECK("write strobe", d, mem_write_out)
        if (d)
            `CHECK("write data", res, mem_wdata_out)
        if (!d)
            exp_wreg = res;
        exp_flags = {res[7], rd == 8'h7F, res == 8'h00, rd[3:0] == 4'hF, rd == 8'hFF};
        step();
        `CHECK("accumulator", exp_wreg, wreg_out)
        `CHECK("flags", exp_flags, flags_out)
    endtask

    task automatic jmp(input logic [15:0] w1, input logic [15:0] w2, input logic ok);
        wait_q1();
        instr_word_in  = w1;
        next_word_in   = w2;
        instr_valid_in = 1'b1;
        step();
        instr_valid_in = 1'b0;
        `CHECK("jump read strobe", 1'b0, mem_read_out)
        repeat (2) step();
        `CHECK("counter load", ok, pc_write_out)
        if (ok)
            exp_pc = {w2[11:0], w1[7:0], 1'b0};
        step();
        `CHECK("counter", exp_pc, pc_out)
        `CHECK("flush", ok, flush_out)
        `CHECK("jump flags", exp_flags, flags_out)
        `CHECK("jump accumulator", exp_wreg, wreg_out)
        if (ok)
        begin
            // a word offered in the no-op cycle must be dropped
            instr_word_in  = {INC_PATTERN, 2'b11, 8'h10};
            instr_valid_in = 1'b1;
            step();
            instr_valid_in = 1'b0;
            `CHECK("flushed read", 1'b0, mem_read_out)
            repeat (3) step();
            `CHECK("flush end", 1'b0, flush_out)
        end
    endtask

    // =====================================================================
    // sequence
    // =====================================================================
    initial
    begin
        n_mismatch      = 0;
        n_tests         = 0;
        reset_in        = 1'b1;
        instr_valid_in  = 1'b0;
        instr_word_in   = 16'h0000;
        next_word_in    = 16'h0000;
        extended_en_in  = 1'b0;
        bank_pointer_in = 4'h0;
        index_base_in   = 12'h000;
        mem_rdata_in    = 8'h00;
        do_reset();
        `CHECK("reset counter", PC_RESET, pc_out)
        `CHECK("reset flags", FLAGS_RESET, flags_out)
        `CHECK("reset quarter", QUARTER_1, quarter)
        `CHECK("reset flush", 1'b0, flush_out)
        $display("test reset done");
        inc(8'h10, 1'b1, 1'b1, 1'b1, 4'h3, 12'h000, 8'h41, 12'h310);
        inc(8'h10, 1'b0, 1'b1, 1'b0, 4'h3, 12'h000, 8'hFF, 12'h310);
        inc(8'h22, 1'b0, 1'b1, 1'b0, 4'hA, 12'h000, 8'h7F, 12'hA22);
        inc(8'h22, 1'b1, 1'b1, 1'b0, 4'hA, 12'h000, 8'h0F, 12'hA22);
        $display("test increment done");
        inc(8'h5F, 1'b1, 1'b0, 1'b1, 4'h3, 12'hFF0, 8'h00, 12'h04F);
        inc(8'h00, 1'b1, 1'b0, 1'b1, 4'h3, 12'h120, 8'h01, 12'h120);
        inc(8'h60, 1'b1, 1'b0, 1'b1, 4'h3, 12'hFF0, 8'h02, 12'hF60);
        inc(8'h20, 1'b1, 1'b0, 1'b0, 4'h3, 12'h400, 8'h03, 12'h020);
        inc(8'h80, 1'b1, 1'b0, 1'b0, 4'h3, 12'h400, 8'h04, 12'hF80);
        $display("test addressing done");
        jmp(16'hEF34, 16'hF012, 1'b1);
        jmp(16'hEFFF, 16'hFFFF, 1'b1);
        jmp(16'hEF00, 16'hF000, 1'b1);
        jmp(16'hEF55, 16'hE012, 1'b0);
        jmp(16'hEE34, 16'hF012, 1'b0);
        jmp(16'h2C10, 16'hF012, 1'b0);
        $display("test jump done");
        jmp(16'hEF34, 16'hF012, 1'b1);
        do_reset();
        `CHECK("second reset counter", PC_RESET, pc_out)
        inc(8'h10, 1'b0, 1'b1, 1'b0, 4'h5, 12'h000, 8'h80, 12'h510);
        $display("test second reset done");
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge clock_in);
        n_mismatch++;
        $display("MISMATCH run length expected end seen limit");
        wrap_up();
    end

endmodule // jump_and_increment_exec_tb
